// ---- core/dspms_multiplier_stage.sv ----
/*
  multiplier front end of the signal-processing block: operand registers,
  shift chains, 9/18/36-bit multipliers with dynamic sign, pipeline register
  and hand-off toward the adder stage or straight out.
  assumes: fabric and neighbour blocks run on ref_clk; the four control sets
  are qualifiers on that one clock; registers reached over a plain port.
*/
`timescale 1ns/10ps
`include "dspms_consts.svh"

module dspms_multiplier_stage
  import dspms_pkg::*;
#(
  parameter int OPW   = 18,                   // operand width of one slot
  parameter int NSLOT = 4,                    // multiplier slots per block
  parameter int NSET  = 4                     // block-wide control sets
) (
  input  wire logic                    ref_clk,              // block clock
  input  wire logic                    srst,                 // sync reset
  input  wire logic [3:0]              regAddr,              // word address
  input  wire logic [31:0]             regWdata,             // write data
  input  wire logic                    regWr,                // write strobe
  input  wire logic                    regRd,                // read strobe
  output logic      [31:0]             regRdata,             // read data
  input  wire logic [NSET-1:0]         setEna,               // set enables
  input  wire logic [NSET-1:0]         setClr,               // set clears
  input  wire logic [NSLOT*OPW-1:0]    dataA,                // A operands
  input  wire logic [NSLOT*OPW-1:0]    dataB,                // B operands
  input  wire logic                    signA,                // A is signed
  input  wire logic                    signB,                // B is signed
  input  wire logic [OPW-1:0]          chainInFirstOperand,  // A chain in
  input  wire logic [OPW-1:0]          chainInSecondOperand, // B chain in
  output logic      [OPW-1:0]          chainOutFirstOperand, // A chain out
  output logic      [OPW-1:0]          chainOutSecondOperand,// B chain out
  output logic      [NSLOT*2*OPW-1:0]  adderProd,            // to adder
  output logic      [NSLOT*2*OPW-1:0]  directProd,           // straight out
  output logic                         prodSigned            // result signed
);

  localparam int NLANE = 2 * NSLOT;           // one lane per operand
  localparam int PW    = 2 * OPW;             // product width of one slot
  localparam int TW    = NSLOT * PW;          // all products side by side
  localparam int HW    = `DSPMS_HALF_W;       // narrow operand width
  localparam int WW    = 2 * OPW;             // wide operand width
  localparam int SELW  = $clog2(NSET);        // set select width

  // ==========================================================
  // software configuration
  dspms_width_t     width_ff;                 // multiplier width
  logic             route_ff;                 // products to adder stage
  logic             pipeUse_ff;               // pipeline register in use
  logic             signReg_ff;               // sign path registered
  logic [NLANE-1:0] useReg_ff;                // operand register in use
  logic [NLANE-1:0] shift_ff;                 // operand loads from chain
  logic [2*NLANE-1:0] opSet_ff;               // set select per operand
  logic [SELW-1:0]  pipeSet_ff;               // set of pipeline register
  logic [SELW-1:0]  signSet_ff;               // set of sign registers
  logic [31:0]      regRdata_ff;              // read answer

  // ==========================================================
  // datapath state
  logic             signA_ff;                 // registered A sign
  logic             signB_ff;                 // registered B sign
  logic [TW-1:0]    pipe_ff;                  // post-multiply register
  logic             pipeSigned_ff;            // sign beside pipe_ff
  logic [TW-1:0]    adderProd_ff;             // hand-off to adder stage
  logic [TW-1:0]    directProd_ff;            // hand-off straight out
  logic             prodSigned_ff;            // sign beside the hand-off

  // ==========================================================
  // combinational nets
  logic             narrow;                   // 9x9 mode
  logic             wide;                     // 36x36 mode
  logic [NLANE-1:0] shiftEff;                 // lane really shifts
  logic [NLANE-1:0] laneClr;                  // selected clear per lane
  logic [NLANE-1:0] laneEna;                  // selected enable per lane
  logic [OPW-1:0]   laneOp    [NLANE];        // operands to multipliers
  logic [OPW-1:0]   laneChain [NLANE];        // chain outputs per lane
  logic             sgnA;                     // sign of A in use
  logic             sgnB;                     // sign of B in use
  logic [TW-1:0]    mulRes;                   // raw products
  logic             pipeOn;                   // pipeline stage in path
  logic [TW-1:0]    stageVal;                 // product after pipeline
  logic             stageSigned;              // sign after pipeline
  dspms_width_t     nxt_width;                // decoded width write

  // ==========================================================
  // mode decode
  assign narrow = (width_ff == DSPMS_W9);
  assign wide   = (width_ff == DSPMS_W36);

  // the widest multiplier takes parallel operands only, so its shifting
  // must be built in the fabric; a lane that does not shift ends the chain
  always_comb begin
    for (int i = 0; i < NLANE; i++) begin
      shiftEff[i] = shift_ff[i] & useReg_ff[i] & ~wide;
    end
  end

  // each lane reads the enable and clear of the set it names
  always_comb begin
    for (int i = 0; i < NLANE; i++) begin
      laneClr[i] = setClr[opSet_ff[2*i +: SELW]];
      laneEna[i] = setEna[opSet_ff[2*i +: SELW]];
    end
  end

  // ==========================================================
  // operand lanes: even index is A, odd is B of the same slot
  // slot s takes its chain from slot s-1; slot 0 from the block before
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    for (genvar o = 0; o < 2; o++) begin : g_op
      localparam int L = 2 * s + o;           // lane index
      logic [OPW-1:0] chainSrc;               // chain input of this lane
      logic [OPW-1:0] parSrc;                 // parallel input of this lane
      if (s == 0) begin : g_head
        assign chainSrc = (o == 0) ? chainInFirstOperand
                                   : chainInSecondOperand;
      end else begin : g_link
        assign chainSrc = laneChain[L-2];
      end
      assign parSrc = (o == 0) ? dataA[s*OPW +: OPW] : dataB[s*OPW +: OPW];
      dspms_operand_lane #(
        .OPW      (OPW)
      ) u_lane (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .narrow   (narrow),
        .useReg   (useReg_ff[L]),
        .shiftEn  (shiftEff[L]),
        .setClr   (laneClr[L]),
        .setEna   (laneEna[L]),
        .parIn    (parSrc),
        .chainIn  (chainSrc),
        .opOut    (laneOp[L]),
        .chainOut (laneChain[L])
      );
    end
  end

  // ==========================================================
  // chain outputs: last slot's registers, straight from flip-flops
  assign chainOutFirstOperand  = laneChain[NLANE-2];
  assign chainOutSecondOperand = laneChain[NLANE-1];

  // ==========================================================
  // sign path: one pair of controls for every multiplier in the block
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      signA_ff <= 1'b0;
      signB_ff <= 1'b0;
    end else if (setClr[signSet_ff]) begin
      signA_ff <= 1'b0;
      signB_ff <= 1'b0;
    end else if (setEna[signSet_ff]) begin
      signA_ff <= signA;
      signB_ff <= signB;
    end
  end

  // registered once to line up with registered operands, else direct
  assign sgnA = signReg_ff ? signA_ff : signA;
  assign sgnB = signReg_ff ? signB_ff : signB;

  // ==========================================================
  // multiply: operands get one extra bit, the sign copy when signed and
  // zero when unsigned, so one signed product covers all four mixes and
  // the low bits keep full precision
  function automatic logic [2*WW-1:0] fullMul(
    input logic [WW-1:0] a,
    input logic [WW-1:0] b,
    input logic          sa,
    input logic          sb,
    input int            w
  );
    logic signed [WW:0]     ea;
    logic signed [WW:0]     eb;
    logic signed [2*WW+1:0] p;
    ea = '0;
    eb = '0;
    for (int k = 0; k <= WW; k++) begin
      ea[k] = (k < w) ? a[k] : (sa & a[w-1]);
      eb[k] = (k < w) ? b[k] : (sb & b[w-1]);
    end
    p = ea * eb;
    return p[2*WW-1:0];
  endfunction

  // ==========================================================
  // product arrangement per width mode
  // 9x9: two 18-bit products per slot; 18x18: one 36-bit per slot;
  // 36x36: slots 0 and 1 join into one operand pair, one 72-bit product
  always_comb begin
    logic [2*WW-1:0] p;
    logic [WW-1:0]   a;
    logic [WW-1:0]   b;
    p = '0;
    a = '0;
    b = '0;
    mulRes = '0;
    unique case (width_ff)
      DSPMS_W9: begin
        for (int s = 0; s < NSLOT; s++) begin
          for (int h = 0; h < 2; h++) begin
            a = '0;
            b = '0;
            a[HW-1:0] = laneOp[2*s][h*HW +: HW];
            b[HW-1:0] = laneOp[2*s+1][h*HW +: HW];
            p = fullMul(a, b, sgnA, sgnB, HW);
            mulRes[s*PW + h*2*HW +: 2*HW] = p[2*HW-1:0];
          end
        end
      end
      DSPMS_W18: begin
        for (int s = 0; s < NSLOT; s++) begin
          a = '0;
          b = '0;
          a[OPW-1:0] = laneOp[2*s];
          b[OPW-1:0] = laneOp[2*s+1];
          p = fullMul(a, b, sgnA, sgnB, OPW);
          mulRes[s*PW +: PW] = p[PW-1:0];
        end
      end
      DSPMS_W36: begin
        a = {laneOp[2], laneOp[0]};
        b = {laneOp[3], laneOp[1]};
        p = fullMul(a, b, sgnA, sgnB, WW);
        mulRes[2*WW-1:0] = p;
      end
    endcase
  end

  // ==========================================================
  // post-multiply register; in 36x36 mode it is always in the path
  // because the wide product is built across it
  assign pipeOn = pipeUse_ff | wide;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pipe_ff       <= '0;
      pipeSigned_ff <= 1'b0;
    end else if (setClr[pipeSet_ff]) begin
      pipe_ff       <= '0;
      pipeSigned_ff <= 1'b0;
    end else if (setEna[pipeSet_ff]) begin
      pipe_ff       <= mulRes;
      pipeSigned_ff <= sgnA | sgnB;
    end
  end

  assign stageVal    = pipeOn ? pipe_ff : mulRes;
  assign stageSigned = pipeOn ? pipeSigned_ff : (sgnA | sgnB);

  // ==========================================================
  // hand-off: the unused destination holds zero so nothing downstream
  // mistakes a stale product for live data
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      adderProd_ff  <= '0;
      directProd_ff <= '0;
      prodSigned_ff <= 1'b0;
    end else begin
      adderProd_ff  <= route_ff ? stageVal : '0;
      directProd_ff <= route_ff ? '0 : stageVal;
      prodSigned_ff <= stageSigned;
    end
  end

  assign adderProd  = adderProd_ff;
  assign directProd = directProd_ff;
  assign prodSigned = prodSigned_ff;

  // ==========================================================
  // width field decode; the spare code falls back to 18x18
  always_comb begin
    unique case (regWdata[`DSPMS_MODE_WID_LSB +: 2])
      `DSPMS_WCODE_9:  nxt_width = DSPMS_W9;
      `DSPMS_WCODE_36: nxt_width = DSPMS_W36;
      default:         nxt_width = DSPMS_W18;
    endcase
  end

  // ==========================================================
  // register writes: mode register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      width_ff   <= DSPMS_W18;
      route_ff   <= 1'b0;
      pipeUse_ff <= 1'b0;
      signReg_ff <= 1'b0;
    end else if (regWr && regAddr == `DSPMS_ADDR_MODE) begin
      width_ff   <= nxt_width;
      route_ff   <= regWdata[`DSPMS_MODE_ROUTE];
      pipeUse_ff <= regWdata[`DSPMS_MODE_PIPE];
      signReg_ff <= regWdata[`DSPMS_MODE_SGNREG];
    end
  end

  // register writes: operand lane configuration
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      useReg_ff <= `DSPMS_RST_BYTE;
      shift_ff  <= `DSPMS_RST_BYTE;
      opSet_ff  <= `DSPMS_RST_SET;
    end else if (regWr) begin
      if (regAddr == `DSPMS_ADDR_USE) begin
        useReg_ff <= regWdata[NLANE-1:0];
      end
      if (regAddr == `DSPMS_ADDR_SHIFT) begin
        shift_ff <= regWdata[NLANE-1:0];
      end
      if (regAddr == `DSPMS_ADDR_SET) begin
        opSet_ff <= regWdata[2*NLANE-1:0];
      end
    end
  end

  // register writes: sets of pipeline and sign registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pipeSet_ff <= `DSPMS_RST_SEL;
      signSet_ff <= `DSPMS_RST_SEL;
    end else if (regWr && regAddr == `DSPMS_ADDR_MISC) begin
      pipeSet_ff <= regWdata[`DSPMS_MISC_PSET_LSB +: SELW];
      signSet_ff <= regWdata[`DSPMS_MISC_SSET_LSB +: SELW];
    end
  end

  // ==========================================================
  // read port: answer stands only in the cycle after the strobe;
  // unmapped words read zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdata_ff <= '0;
    end else if (regRd) begin
      regRdata_ff <= '0;
      unique case (regAddr)
        `DSPMS_ADDR_MODE: begin
          regRdata_ff[`DSPMS_MODE_WID_LSB +: 2] <= width_ff;
          regRdata_ff[`DSPMS_MODE_ROUTE]        <= route_ff;
          regRdata_ff[`DSPMS_MODE_PIPE]         <= pipeUse_ff;
          regRdata_ff[`DSPMS_MODE_SGNREG]       <= signReg_ff;
        end
        `DSPMS_ADDR_USE:   regRdata_ff[NLANE-1:0]   <= useReg_ff;
        `DSPMS_ADDR_SHIFT: regRdata_ff[NLANE-1:0]   <= shift_ff;
        `DSPMS_ADDR_SET:   regRdata_ff[2*NLANE-1:0] <= opSet_ff;
        `DSPMS_ADDR_MISC: begin
          regRdata_ff[`DSPMS_MISC_PSET_LSB +: SELW] <= pipeSet_ff;
          regRdata_ff[`DSPMS_MISC_SSET_LSB +: SELW] <= signSet_ff;
        end
        `DSPMS_ADDR_STAT: begin
          // live state: signs in use, lanes really shifting
          regRdata_ff[0]         <= sgnA;
          regRdata_ff[1]         <= sgnB;
          regRdata_ff[2]         <= prodSigned_ff;
          regRdata_ff[3]         <= pipeOn;
          regRdata_ff[8 +: NLANE] <= shiftEff;
        end
        default: regRdata_ff <= '0;           // unmapped
      endcase
    end else begin
      regRdata_ff <= '0;
    end
  end

  assign regRdata = regRdata_ff;

endmodule // dspms_multiplier_stage

// ---- core/dspms_consts.svh ----
/*
  constants of the multiplier stage: register word addresses, field
  positions, reset values and width codes.
  assumes: included by its bare name from the core/ design files.
*/
`ifndef DSPMS_CONSTS_SVH
`define DSPMS_CONSTS_SVH

// ==========================================================
// register word addresses
`define DSPMS_ADDR_MODE   4'h0
`define DSPMS_ADDR_USE    4'h1
`define DSPMS_ADDR_SHIFT  4'h2
`define DSPMS_ADDR_SET    4'h3
`define DSPMS_ADDR_MISC   4'h4
`define DSPMS_ADDR_STAT   4'h5

// ==========================================================
// field positions
`define DSPMS_MODE_WID_LSB  0
`define DSPMS_MODE_ROUTE    2
`define DSPMS_MODE_PIPE     3
`define DSPMS_MODE_SGNREG   4
`define DSPMS_MISC_PSET_LSB 0
`define DSPMS_MISC_SSET_LSB 2

// ==========================================================
// width codes in the mode register
`define DSPMS_WCODE_9   2'h0
`define DSPMS_WCODE_18  2'h1
`define DSPMS_WCODE_36  2'h2

// ==========================================================
// reset values and limits
`define DSPMS_RST_BYTE  8'h00
`define DSPMS_RST_SET   16'h0000
`define DSPMS_RST_SEL   2'h0
`define DSPMS_HALF_W    9
`define DSPMS_CHAIN_MAX 224

`endif

// ---- core/dspms_pkg.sv ----
/*
  types of the multiplier stage.
  assumes: compiled before every core/ module.
*/
package dspms_pkg;
  // multiplier width configuration of the whole block
  typedef enum logic [1:0] {DSPMS_W9, DSPMS_W18, DSPMS_W36} dspms_width_t;
endpackage

// ---- core/dspms_operand_lane.sv ----
/*
  one operand input register of one multiplier slot: bypass, parallel load
  or shift-chain load, with an optional split into two 9-bit halves.
  assumes: clear and enable come already selected from the block-wide sets,
  on the same clock as ref_clk.
*/
`timescale 1ns/10ps
`include "dspms_consts.svh"

module dspms_operand_lane
  import dspms_pkg::*;
#(
  parameter int OPW = 18                      // operand width of one slot
) (
  input  wire logic           ref_clk,        // block clock
  input  wire logic           srst,           // synchronous reset
  input  wire logic           narrow,         // slot runs as two 9-bit halves
  input  wire logic           useReg,         // register in path, else bypass
  input  wire logic           shiftEn,        // load from chain, else parallel
  input  wire logic           setClr,         // selected clear of this lane
  input  wire logic           setEna,         // selected enable of this lane
  input  wire logic [OPW-1:0] parIn,          // parallel operand from fabric
  input  wire logic [OPW-1:0] chainIn,        // shift input from previous lane
  output logic      [OPW-1:0] opOut,          // operand to the multiplier
  output logic      [OPW-1:0] chainOut        // shift output to next lane
);

  localparam int HW = `DSPMS_HALF_W;          // width of one narrow half

  logic [OPW-1:0] opReg_ff;                   // captured operand
  logic [OPW-1:0] nxt_opReg;                  // value to capture

  // ==========================================================
  // load source
  // in narrow mode the low half takes the chain and hands on to the high
  // half, so each 9-bit multiplier is one stage of the chain
  always_comb begin
    if (!shiftEn) begin
      nxt_opReg = parIn;                      // parallel load
    end else if (narrow) begin
      nxt_opReg = '0;
      nxt_opReg[HW-1:0] = chainIn[HW-1:0];
      nxt_opReg[2*HW-1:HW] = opReg_ff[HW-1:0];
    end else begin
      nxt_opReg = chainIn;                    // whole word stage
    end
  end

  // ==========================================================
  // operand register: clear wins over enable
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      opReg_ff <= '0;
    end else if (setClr) begin
      opReg_ff <= '0;
    end else if (setEna) begin
      opReg_ff <= nxt_opReg;
    end
  end

  // ==========================================================
  // outputs: bypass skips the register entirely
  assign opOut = useReg ? opReg_ff : parIn;

  // narrow chains pass on the high half; a full word passes whole
  always_comb begin
    chainOut = opReg_ff;
    if (narrow) begin
      chainOut = '0;
      chainOut[HW-1:0] = opReg_ff[2*HW-1:HW];
    end
  end

endmodule // dspms_operand_lane

// ---- verif/dspms_checker.sv ----
/* port checker of the multiplier stage
   assumes: bound onto the stage top, one clock */
`timescale 1ns/10ps
`include "dspms_consts.svh"
module dspms_checker
  import dspms_pkg::*;
#(parameter int OPW = 18, parameter int NSLOT = 4, parameter int NSET = 4) (
  input wire logic                   ref_clk, srst, regWr, regRd, signA, signB, prodSigned, // controls
  input wire logic [3:0]             regAddr,                                   // address
  input wire logic [31:0]            regWdata, regRdata,                        // bus data
  input wire logic [NSET-1:0]        setEna, setClr,                            // sets
  input wire logic [NSLOT*OPW-1:0]   dataA, dataB,                              // operands
  input wire logic [OPW-1:0]         chainInFirstOperand, chainInSecondOperand,   // chain in
  input wire logic [OPW-1:0]         chainOutFirstOperand, chainOutSecondOperand, // chain out
  input wire logic [NSLOT*2*OPW-1:0] adderProd, directProd                      // products
);
  // ==========
  // shadows: checks wait until config and signs have settled
  logic [4:0] mode_ff;              // last mode word
  logic [2:0] cfgAge_ff, sgnAge_ff; // saturating quiet counts
  logic [1:0] sgn_ff;               // signs one cycle back
  always_ff @(posedge ref_clk) begin
    sgn_ff <= {signA, signB};
    if (srst) begin
      mode_ff <= 5'h01;
      cfgAge_ff <= 3'h0;
      sgnAge_ff <= 3'h0;
    end else begin
      if (regWr && regAddr == `DSPMS_ADDR_MODE) mode_ff <= regWdata[4:0];
      cfgAge_ff <= regWr ? 3'h0 : cfgAge_ff + 3'(cfgAge_ff != 3'h7);
      sgnAge_ff <= (sgn_ff != {signA, signB}) ? 3'h0 : sgnAge_ff + 3'(sgnAge_ff != 3'h7);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rdIdle; !$past(regRd) |-> regRdata == 32'h0; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_rdMode; regRd && regAddr == `DSPMS_ADDR_MODE |=> regRdata[4:0] == mode_ff; endproperty
  a_rdMode: assert property (p_rdMode) else $error("mode readback wrong");
  property p_rdVoid; regRd && regAddr > `DSPMS_ADDR_STAT |=> regRdata == 32'h0; endproperty
  a_rdVoid: assert property (p_rdVoid) else $error("unmapped read not zero");
  property p_rstOut; $past(srst) |-> directProd == '0 && adderProd == '0 && !prodSigned; endproperty
  a_rstOut: assert property (p_rstOut) else $error("outputs not clear");
  property p_oneWay; adderProd == '0 || directProd == '0; endproperty
  a_oneWay: assert property (p_oneWay) else $error("both routes busy");
  property p_toAdder; cfgAge_ff > 3'h3 && mode_ff[`DSPMS_MODE_ROUTE] |-> directProd == '0; endproperty
  a_toAdder: assert property (p_toAdder) else $error("direct not idle");
  property p_wide; cfgAge_ff > 3'h3 && mode_ff[1:0] == `DSPMS_WCODE_36 |-> directProd[NSLOT*2*OPW-1:4*OPW] == '0;
  endproperty
  a_wide: assert property (p_wide) else $error("wide upper not zero");
  property p_chain9; cfgAge_ff > 3'h3 && mode_ff[1:0] == `DSPMS_WCODE_9 |-> chainOutFirstOperand[OPW-1:9] == '0;
  endproperty
  a_chain9: assert property (p_chain9) else $error("narrow chain upper set");
  property p_sign; sgnAge_ff > 3'h4 |-> prodSigned == $past(signA | signB); endproperty
  a_sign: assert property (p_sign) else $error("result sign wrong");
endmodule // dspms_checker
bind dspms_multiplier_stage dspms_checker #(.OPW(OPW), .NSLOT(NSLOT), .NSET(NSET)) dspms_checker_inst (.*);

// ---- verif/dspms_fabric_model.sv ----
/* upstream neighbour lane feeding the chain inputs
   assumes: same clock as the stage */
`timescale 1ns/10ps
module dspms_fabric_model (
  input wire logic        ref_clk, srst, step, // clock, reset, advance
  input wire logic [17:0] feed,                // upstream sample
  output logic     [17:0] chainA, chainB       // registered shift outputs
);
  // ==========
  // neighbour register drives the next block's chain directly
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chainA <= 18'h0;
      chainB <= 18'h0;
    end else if (step) begin
      chainA <= feed;
      chainB <= ~feed;
    end
  end
endmodule // dspms_fabric_model

// ---- verif/test_dsp_multiplier_stage.sv ----
/* self-checking bench of the multiplier stage
   assumes: design, checker and model compiled first */
`timescale 1ns/10ps
module test_dsp_multiplier_stage
  import dspms_pkg::*;
;
  logic         ref_clk, srst, regWr, regRd, signA, signB, step, prodSigned; // controls
  logic [3:0]   regAddr, setEna, setClr;                                     // address, sets
  logic [31:0]  regWdata, regRdata;                                          // bus data
  logic [71:0]  dataA, dataB;                                                // operands
  logic [17:0]  chainInFirstOperand, chainInSecondOperand, feed;             // chain in
  logic [17:0]  chainOutFirstOperand, chainOutSecondOperand;                 // chain out
  logic [143:0] adderProd, directProd;                                       // products
  int           n_fail, comparisons, cycles;                                 // tallies
  dspms_multiplier_stage dspms_multiplier_stage_inst (.*);
  dspms_fabric_model dspms_fabric_model_inst (.ref_clk, .srst, .step, .feed, .chainA(chainInFirstOperand),
    .chainB(chainInSecondOperand));
  // ==========
  // shared helpers
  task automatic check(input logic [143:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 check(144'(regRdata), 144'(e));
  endtask
  task automatic tick(input int n); // fixed latencies from the note
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [35:0] mul(logic [17:0] a, b, logic sa, sb); // bench reference
    mul = 36'({{18{sa & a[17]}}, a} * {{18{sb & b[17]}}, b});
  endfunction
  // ==========
  // scenarios
  task automatic t_regs;
    rd(4'h0, 32'h1);
    rd(4'h1, 32'h0);
    wr(4'h3, 32'ha5c3);
    rd(4'h3, 32'ha5c3);
    rd(4'h9, 32'h0);
    wr(4'h3, 32'h000a);
  endtask
  task automatic t_sign; // every sign pair, negative operands
    wr(4'h0, 32'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {signA, signB, dataA[17:0], dataB[17:0]} <= {i[1], i[0], 18'h20003, 18'h3fffb};
      tick(1);
      check(directProd[35:0], mul(18'h20003, 18'h3fffb, i[1], i[0]));
      check(prodSigned, i[1] | i[0]);
    end
  endtask
  task automatic t_route_pipe; // adder route, then pipeline depth
    wr(4'h0, 32'h05);
    tick(5);
    check(adderProd[35:0], mul(18'h20003, 18'h3fffb, 1'b1, 1'b1));
    wr(4'h0, 32'h09);
    dataA[17:0] <= 18'h00011;
    tick(1);
    check(directProd[35:0], mul(18'h20003, 18'h3fffb, 1'b1, 1'b1));
    tick(1);
    check(directProd[35:0], mul(18'h00011, 18'h3fffb, 1'b1, 1'b1));
  endtask
  task automatic t_widths; // one wide product, then two narrow halves
    {signA, signB} <= 2'b00;
    wr(4'h0, 32'h02);
    {dataA[35:0], dataB[35:0]} <= {36'h123456789, 36'hfedcba987};
    tick(5);
    check(directProd[71:0], 72'(36'h123456789) * 72'(36'hfedcba987));
    wr(4'h0, 32'h00);
    {dataA[17:0], dataB[17:0]} <= {9'h1ff, 9'h003, 9'h002, 9'h1ff};
    tick(5);
    check(directProd[35:0], {18'h003fe, 18'h005fd});
  endtask
  task automatic t_oreg; // slot 0 registers on set 2: hold and clear
    wr(4'h0, 32'h01);
    wr(4'h1, 32'h03);
    {dataA[17:0], dataB[17:0]} <= {18'h5, 18'h7};
    tick(2);
    check(directProd[35:0], 36'h23);
    {setEna[2], dataA[17:0]} <= {1'b0, 18'h9};
    tick(3);
    check(directProd[35:0], 36'h23);
    setClr[2] <= 1'b1;
    @(posedge ref_clk);
    {setClr[2], setEna[2]} <= 2'b01;
    tick(1);
    check(directProd[35:0], 36'h0);
  endtask
  task automatic t_chain; // A shifts through all slots, B parallel
    wr(4'h1, 32'hff);
    wr(4'h2, 32'h55);
    dataB[71:54] <= 18'h3;
    for (int k = 1; k < 11; k++) begin
      @(posedge ref_clk);
      {step, feed} <= {1'b1, 18'(k)};
    end
    tick(1);
    check(chainOutFirstOperand, 18'h6);
    check(chainOutSecondOperand, 18'h3);
    check(directProd[143:108], 36'hf);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin // hang guard
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    {srst, regWr, regRd, signA, signB, step, regAddr, regWdata} = {1'b1, 41'h0};
    {setEna, setClr, dataA, dataB, feed} = {4'hf, 166'h0};
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs;
    t_sign;
    t_route_pipe;
    t_widths;
    t_oreg;
    t_chain;
    stop_test;
  end
endmodule // test_dsp_multiplier_stage
